// [logic/rfmc_pkg.sv]
//
// Overview of operation
// RULE1: reverse input only tx, window, reverse
// RULE2: unselected sense inputs switched to ground
// RULE3: high-class forward: tx, class 2-4, window
// RULE4: low-class forward: tx, class 1, window
// RULE5: bias shutdown follows software bit
// RULE6: antenna low if period A stronger
// RULE7: period A is twelve clocks after rise
// RULE8: serial out driven only while selected
// RULE9: select low enables serial, high ignores
// RULE10: serial state kept across clock pauses
// RULE11: signal strength active receive, window high
// RULE12: converter sampled at window end
// RULE13: direct channel bypasses peak detector
// RULE14: sense bias only during power sensing
// RULE15: direction from upconverter byte bit seven
// RULE16: two-bit power class in bias byte
// RULE17: channel bit selects peak or direct
// RULE18: frame is eight command, eight data
// RULE19: best antenna held until next result
package rfmc_pkg;

  // ---------------------------------------------
  // serial frame
  // ---------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 8;
  localparam logic [3:0] CNT_CMD_LAST = 4'h7;
  localparam logic [3:0] CNT_FRAME_LAST = 4'hf;

  // ---------------------------------------------
  // addresses and fields
  // ---------------------------------------------
  localparam logic [2:0] ADDR_OSC_TUNE = 3'h0;
  localparam logic [2:0] ADDR_UPCONV = 3'h1;
  localparam logic [2:0] ADDR_MODULATOR = 3'h2;
  localparam logic [2:0] ADDR_AMP_BIAS = 3'h3;
  localparam logic [2:0] ADDR_ADC_READ = 3'h7;
  localparam int DIR_BIT = 7;
  localparam int CHAN_BIT = 7;
  localparam int SHDN_BIT = 7;
  localparam int CLASS_MSB = 7;
  localparam int CLASS_LSB = 6;
  localparam logic [1:0] CLASS_1 = 2'h0;
  localparam logic DIR_REVERSE = 1'b0;

  // ---------------------------------------------
  // diversity timing
  // ---------------------------------------------
  localparam int PERIOD_A_CLOCKS = 12;

  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef struct packed {
    logic [5:0] osc_tune;
    logic [6:0] upconv;
    logic [6:0] modulator;
    logic [5:0] amp_bias;
  } rfmc_dac_type;

  typedef struct packed {
    logic reverse_sel;
    logic fwd_high_sel;
    logic fwd_low_sel;
  } rfmc_sense_type;

  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_PERIOD_A = 3'b010,
    DIV_PERIOD_B = 3'b100
  } rfmc_div_state_type;

  localparam rfmc_dac_type DAC_RESET = '0;

endpackage

// [logic/rfmc_sync.sv]
module rfmc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;
endmodule // rfmc_sync

// [logic/rfmc_top.sv]
module rfmc_top
  import rfmc_pkg::*;
#(
  parameter int PERIOD_A_LEN = rfmc_pkg::PERIOD_A_CLOCKS
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // serial link
  input wire logic serial_clock,
  input wire logic serial_cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  // measurement strobes
  input wire logic tx_mode_input,
  input wire logic measurement_window_input,
  input wire logic diversity_window_input,
  // converter side
  input wire logic [7:0] adc_data_in,
  input wire logic [7:0] rssi_level_in,
  output logic adc_sample,
  output logic direct_channel,
  output logic rssi_enable,
  // power sense
  output rfmc_pkg::rfmc_sense_type sense_select,
  output rfmc_pkg::rfmc_sense_type ground_switch,
  output logic sense_bias_output,
  // control outputs
  output logic bias_shutdown_output,
  output logic best_antenna_output,
  output rfmc_pkg::rfmc_dac_type dac_codes
);
  import rfmc_pkg::*;

  // ---------------------------------------------
  // serial link domain
  // ---------------------------------------------
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [FRAME_BITS-2:0] shift_r;
  logic [FRAME_BITS-2:0] shift_nxt;
  logic [7:0] out_sr_r;
  logic [7:0] out_sr_nxt;
  logic sout_r;
  logic sout_nxt;
  logic [FRAME_BITS-1:0] word_r = '0;
  logic [FRAME_BITS-1:0] word_nxt;
  logic frame_tgl_r = 1'b0;
  logic frame_tgl_nxt;
  logic [7:0] adc_result_r;
  logic [CMD_BITS-1:0] cmd_now;

  always_comb begin
    cmd_now = {shift_r[CMD_BITS-2:0], serial_in};
    bit_cnt_nxt = bit_cnt_r + 4'h1;
    shift_nxt = {shift_r[FRAME_BITS-3:0], serial_in};
    out_sr_nxt = {out_sr_r[6:0], 1'b0};
    sout_nxt = out_sr_r[7];
    word_nxt = word_r;
    frame_tgl_nxt = frame_tgl_r;
    // RULE18 command then data
    if (bit_cnt_r == CNT_CMD_LAST) begin
      if (cmd_now[2:0] == ADDR_ADC_READ) begin
        out_sr_nxt = {adc_result_r[6:0], 1'b0};
        sout_nxt = adc_result_r[7];
      end else begin
        out_sr_nxt = '0;
        sout_nxt = 1'b0;
      end
    end
    if (bit_cnt_r == CNT_FRAME_LAST) begin
      word_nxt = {shift_r, serial_in};
      frame_tgl_nxt = ~frame_tgl_r;
    end
  end

  // RULE9 select high clears frame
  // RULE10 no clock, no state change
  always_ff @(posedge serial_clock or posedge serial_cs_n) begin
    if (serial_cs_n) begin
      bit_cnt_r <= 4'h0;
      shift_r <= '0;
      out_sr_r <= '0;
      sout_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      out_sr_r <= out_sr_nxt;
      sout_r <= sout_nxt;
    end
  end

  always_ff @(posedge serial_clock) begin
    word_r <= word_nxt;
    frame_tgl_r <= frame_tgl_nxt;
  end

  assign serial_out = sout_r;

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic [4:0] sync_in;
  logic [4:0] sync_s;
  logic tgl_s;
  logic cs_n_s;
  logic tx_s;
  logic win_s;
  logic dwin_s;

  assign sync_in = {frame_tgl_r, serial_cs_n, tx_mode_input,
                    measurement_window_input, diversity_window_input};

  rfmc_sync #(
    .WIDTH(5)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(sync_in),
    .sync_out(sync_s)
  );

  assign {tgl_s, cs_n_s, tx_s, win_s, dwin_s} = sync_s;

  // ---------------------------------------------
  // write decode and configuration
  // ---------------------------------------------
  logic tgl_d_r;
  logic win_d_r;
  logic dwin_d_r;
  logic dir_r;
  logic dir_nxt;
  logic chan_r;
  logic chan_nxt;
  logic shdn_r;
  logic shdn_nxt;
  logic [1:0] class_r;
  logic [1:0] class_nxt;
  rfmc_dac_type dac_r;
  rfmc_dac_type dac_nxt;
  logic out_en_r;
  logic frame_done;
  logic [CMD_BITS-1:0] wr_cmd;
  logic [7:0] wr_data;

  always_comb begin
    frame_done = tgl_s ^ tgl_d_r;
    wr_cmd = word_r[FRAME_BITS-1:CMD_BITS];
    wr_data = word_r[CMD_BITS-1:0];
    dir_nxt = dir_r;
    chan_nxt = chan_r;
    shdn_nxt = shdn_r;
    class_nxt = class_r;
    dac_nxt = dac_r;
    if (frame_done) begin
      unique case (wr_cmd[2:0])
        ADDR_OSC_TUNE: begin
          dac_nxt.osc_tune = wr_data[5:0];
          // RULE5 shutdown bit
          shdn_nxt = wr_data[SHDN_BIT];
        end
        ADDR_UPCONV: begin
          dac_nxt.upconv = wr_data[6:0];
          // RULE15 direction bit
          dir_nxt = wr_data[DIR_BIT];
        end
        ADDR_MODULATOR: begin
          dac_nxt.modulator = wr_data[6:0];
          // RULE17 channel bit
          chan_nxt = wr_data[CHAN_BIT];
        end
        ADDR_AMP_BIAS: begin
          dac_nxt.amp_bias = wr_data[5:0];
          // RULE16 power class field
          class_nxt = wr_data[CLASS_MSB:CLASS_LSB];
        end
        default: begin
          dac_nxt = dac_r;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tgl_d_r <= 1'b0;
      dir_r <= DIR_REVERSE;
      chan_r <= 1'b0;
      shdn_r <= 1'b0;
      class_r <= CLASS_1;
      dac_r <= DAC_RESET;
      out_en_r <= 1'b0;
    end else begin
      tgl_d_r <= tgl_s;
      dir_r <= dir_nxt;
      chan_r <= chan_nxt;
      shdn_r <= shdn_nxt;
      class_r <= class_nxt;
      dac_r <= dac_nxt;
      // RULE8 drive only while selected
      out_en_r <= ~cs_n_s;
    end
  end

  assign serial_out_en = out_en_r;
  assign dac_codes = dac_r;
  assign bias_shutdown_output = shdn_r;
  assign direct_channel = chan_r;

  // ---------------------------------------------
  // measurement path
  // ---------------------------------------------
  rfmc_sense_type sel_r;
  rfmc_sense_type sel_nxt;
  rfmc_sense_type gnd_r;
  rfmc_sense_type gnd_nxt;
  logic rssi_en_r;
  logic rssi_en_nxt;
  logic bias_en_r;
  logic bias_en_nxt;
  logic sample_r;
  logic sample_nxt;
  logic [7:0] adc_result_nxt;
  logic sense_on;

  always_comb begin
    sense_on = tx_s & win_s;
    // RULE1 reverse select
    sel_nxt.reverse_sel = sense_on & (dir_r == DIR_REVERSE);
    // RULE3 high class forward
    sel_nxt.fwd_high_sel = sense_on & (dir_r != DIR_REVERSE) & (class_r != CLASS_1);
    // RULE4 low class forward
    sel_nxt.fwd_low_sel = sense_on & (dir_r != DIR_REVERSE) & (class_r == CLASS_1);
    // RULE2 ground unselected inputs
    gnd_nxt = ~sel_nxt;
    // RULE11 receive window only
    rssi_en_nxt = ~tx_s & win_s;
    // RULE14 bias during sensing
    bias_en_nxt = sense_on;
    // RULE12 sample at window end
    sample_nxt = win_d_r & ~win_s;
    // RULE13 converter value taken either path
    adc_result_nxt = sample_r ? adc_data_in : adc_result_r;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      win_d_r <= 1'b0;
      sel_r <= '0;
      gnd_r <= '1;
      rssi_en_r <= 1'b0;
      bias_en_r <= 1'b0;
      sample_r <= 1'b0;
      adc_result_r <= '0;
    end else begin
      win_d_r <= win_s;
      sel_r <= sel_nxt;
      gnd_r <= gnd_nxt;
      rssi_en_r <= rssi_en_nxt;
      bias_en_r <= bias_en_nxt;
      sample_r <= sample_nxt;
      adc_result_r <= adc_result_nxt;
    end
  end

  assign sense_select = sel_r;
  assign ground_switch = gnd_r;
  assign rssi_enable = rssi_en_r;
  assign sense_bias_output = bias_en_r;
  assign adc_sample = sample_r;

  // ---------------------------------------------
  // antenna diversity
  // ---------------------------------------------
  rfmc_div_state_type div_r;
  rfmc_div_state_type div_nxt;
  logic [7:0] period_cnt_r;
  logic [7:0] period_cnt_nxt;
  logic [7:0] peak_a_r;
  logic [7:0] peak_a_nxt;
  logic [7:0] peak_b_r;
  logic [7:0] peak_b_nxt;
  logic best_r;
  logic best_nxt;
  logic dwin_rise;
  logic dwin_fall;

  always_comb begin
    dwin_rise = dwin_s & ~dwin_d_r;
    dwin_fall = ~dwin_s & dwin_d_r;
    div_nxt = div_r;
    period_cnt_nxt = period_cnt_r;
    peak_a_nxt = peak_a_r;
    peak_b_nxt = peak_b_r;
    // RULE19 hold result
    best_nxt = best_r;
    unique case (div_r)
      DIV_IDLE: begin
        if (dwin_rise) begin
          div_nxt = DIV_PERIOD_A;
          period_cnt_nxt = 8'h01;
          peak_a_nxt = rssi_level_in;
          peak_b_nxt = '0;
        end
      end
      // RULE7 twelve clock period A
      DIV_PERIOD_A: begin
        if (rssi_level_in > peak_a_r) begin
          peak_a_nxt = rssi_level_in;
        end
        period_cnt_nxt = period_cnt_r + 8'h01;
        if (period_cnt_r == 8'(PERIOD_A_LEN)) begin
          div_nxt = DIV_PERIOD_B;
          peak_a_nxt = peak_a_r;
        end
        if (dwin_fall) begin
          div_nxt = DIV_IDLE;
        end
      end
      DIV_PERIOD_B: begin
        if (rssi_level_in > peak_b_r) begin
          peak_b_nxt = rssi_level_in;
        end
        if (dwin_fall) begin
          div_nxt = DIV_IDLE;
          // RULE6 compare and latch
          best_nxt = ~(peak_a_r > peak_b_r);
        end
      end
      default: begin
        div_nxt = DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dwin_d_r <= 1'b0;
      div_r <= DIV_IDLE;
      period_cnt_r <= '0;
      peak_a_r <= '0;
      peak_b_r <= '0;
      best_r <= 1'b0;
    end else begin
      dwin_d_r <= dwin_s;
      div_r <= div_nxt;
      period_cnt_r <= period_cnt_nxt;
      peak_a_r <= peak_a_nxt;
      peak_b_r <= peak_b_nxt;
      best_r <= best_nxt;
    end
  end

  assign best_antenna_output = best_r;

endmodule // rfmc_top

// [testbench/rfmc_chk.sv]
module rfmc_chk
  import rfmc_pkg::*;
#(
  parameter int PERIOD_A_LEN = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // watched ports
  input wire logic serial_cs_n,
  input wire logic serial_out_en,
  input wire logic tx_mode_input,
  input wire logic measurement_window_input,
  input wire logic diversity_window_input,
  input wire logic adc_sample,
  input wire logic rssi_enable,
  input wire rfmc_pkg::rfmc_sense_type sense_select,
  input wire rfmc_pkg::rfmc_sense_type ground_switch,
  input wire logic sense_bias_output,
  input wire logic best_antenna_output
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  property p_bias;
    $rose(sense_bias_output) |-> $past(tx_mode_input, 3) && $past(measurement_window_input, 3);
  endproperty
  a_bias: assert property (p_bias) else $error("sense bias rose without tx window");
  property p_sw;
    ground_switch == ~sense_select;
  endproperty
  a_sw: assert property (p_sw) else $error("ground switch not inverse of select");
  property p_excl;
    !(rssi_enable && sense_bias_output);
  endproperty
  a_excl: assert property (p_excl) else $error("rssi and sense bias together");
  property p_one;
    $onehot0(sense_select);
  endproperty
  a_one: assert property (p_one) else $error("several sense inputs selected");
  property p_sel;
    (|sense_select) |-> sense_bias_output;
  endproperty
  a_sel: assert property (p_sel) else $error("sense input selected outside tx window");
  property p_en;
    $fell(serial_cs_n) |-> ##[2:5] serial_out_en;
  endproperty
  a_en: assert property (p_en) else $error("serial out not enabled");
  property p_dis;
    serial_cs_n [*5] |-> !serial_out_en;
  endproperty
  a_dis: assert property (p_dis) else $error("serial out driven while deselected");
  property p_smp;
    adc_sample |-> !rssi_enable && !sense_bias_output ##1 !adc_sample;
  endproperty
  a_smp: assert property (p_smp) else $error("sample pulse wrong");
  property p_ant;
    diversity_window_input && $past(diversity_window_input, 4) |-> $stable(best_antenna_output);
  endproperty
  a_ant: assert property (p_ant) else $error("antenna result moved in window");
endmodule // rfmc_chk

bind rfmc_top rfmc_chk #(.PERIOD_A_LEN(PERIOD_A_LEN)) u_chk (
  .core_clk(core_clk), .srst(srst), .serial_cs_n(serial_cs_n),
  .serial_out_en(serial_out_en), .tx_mode_input(tx_mode_input),
  .measurement_window_input(measurement_window_input),
  .diversity_window_input(diversity_window_input), .adc_sample(adc_sample),
  .rssi_enable(rssi_enable), .sense_select(sense_select), .ground_switch(ground_switch),
  .sense_bias_output(sense_bias_output), .best_antenna_output(best_antenna_output)
);

// [testbench/rfmc_host.sv]
module rfmc_host (
  // serial link
  output logic serial_clock,
  output logic serial_cs_n,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clock = 1'b0;
    serial_cs_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    serial_cs_n = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #62.5 serial_clock = 1'b1;
      #62.5;
      if (i >= 1 && i <= 8) rd[i-1] = serial_out;
      serial_clock = 1'b0;
      if (i == 10) #1000;
    end
    #62.5 serial_cs_n = 1'b1;
    serial_in = ~serial_in;
  endtask
  task automatic stray(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #62.5 serial_clock = 1'b1;
      #62.5 serial_clock = 1'b0;
    end
  endtask
endmodule // rfmc_host

// [testbench/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rfmc_pkg::*;
  logic core_clk, srst, tx_mode_input, measurement_window_input, diversity_window_input;
  logic serial_clock, serial_cs_n, serial_in, serial_out, serial_out_en, adc_sample;
  logic direct_channel, rssi_enable, sense_bias_output, bias_shutdown_output;
  logic best_antenna_output;
  logic [7:0] adc_data_in, rssi_level_in, rd;
  rfmc_sense_type sense_select, ground_switch;
  rfmc_dac_type dac_codes;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;

  rfmc_top #(.PERIOD_A_LEN(PERIOD_A_CLOCKS)) u_dut (
    .core_clk(core_clk), .srst(srst), .serial_clock(serial_clock),
    .serial_cs_n(serial_cs_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .tx_mode_input(tx_mode_input),
    .measurement_window_input(measurement_window_input),
    .diversity_window_input(diversity_window_input), .adc_data_in(adc_data_in),
    .rssi_level_in(rssi_level_in), .adc_sample(adc_sample), .direct_channel(direct_channel),
    .rssi_enable(rssi_enable), .sense_select(sense_select), .ground_switch(ground_switch),
    .sense_bias_output(sense_bias_output), .bias_shutdown_output(bias_shutdown_output),
    .best_antenna_output(best_antenna_output), .dac_codes(dac_codes)
  );
  rfmc_host u_host (
    .serial_clock(serial_clock), .serial_cs_n(serial_cs_n),
    .serial_in(serial_in), .serial_out(serial_out)
  );

  // ----------------------------------
  // clock, timeout, helpers
  // ----------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      final_report();
    end
  end
  task cmp(input logic [25:0] got, input logic [25:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    u_host.xfer({5'h00, a, d}, rd);
    cyc(8);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------
  // scenarios
  // ----------------------------------
  task t_sense;
    logic [2:0] e;
    tx_mode_input = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_UPCONV, {i[2], 7'h05});
      wr(ADDR_AMP_BIAS, {i[1:0], 6'h2a});
      e = {!i[2], i[2] && i[1:0] != 2'h0, i[2] && i[1:0] == 2'h0};
      measurement_window_input = 1'b1;
      cyc(6);
      cmp(sense_select, e);
      cmp(ground_switch, {~e});
      cmp(sense_bias_output, 1'b1);
      cmp(dac_codes.upconv, 7'h05);
      cmp(dac_codes.amp_bias, 6'h2a);
      measurement_window_input = 1'b0;
      cyc(6);
      cmp(sense_select, 3'h0);
    end
    $display("t_sense done");
  endtask
  task t_rssi;
    tx_mode_input = 1'b0;
    adc_data_in = 8'ha5;
    measurement_window_input = 1'b1;
    cyc(6);
    cmp({rssi_enable, sense_bias_output, sense_select}, 5'h10);
    measurement_window_input = 1'b0;
    cyc(6);
    adc_data_in = 8'h3c;
    u_host.xfer({5'h00, ADDR_ADC_READ, 8'h00}, rd);
    cmp(rd, 8'ha5);
    cyc(8);
    wr(ADDR_MODULATOR, 8'h91);
    cmp(direct_channel, 1'b1);
    cmp(dac_codes.modulator, 7'h11);
    wr(ADDR_MODULATOR, 8'h11);
    cmp(direct_channel, 1'b0);
    $display("t_rssi done");
  endtask
  task div(input logic [7:0] a, input logic [7:0] b, input int len, input logic e);
    rssi_level_in = a;
    diversity_window_input = 1'b1;
    cyc(14);
    rssi_level_in = b;
    cyc(len);
    diversity_window_input = 1'b0;
    cyc(6);
    cmp(best_antenna_output, e);
  endtask
  task t_ant;
    div(8'hc0, 8'h20, 20, 1'b0);
    div(8'h20, 8'hc0, 20, 1'b1);
    rssi_level_in = 8'hf0;
    diversity_window_input = 1'b1;
    cyc(6);
    diversity_window_input = 1'b0;
    cyc(6);
    cmp(best_antenna_output, 1'b1);
    $display("t_ant done");
  endtask
  task t_ctrl;
    wr(ADDR_OSC_TUNE, 8'h80);
    cmp(bias_shutdown_output, 1'b1);
    wr(ADDR_OSC_TUNE, 8'h15);
    cmp({bias_shutdown_output, dac_codes.osc_tune}, 7'h15);
    wr(3'h4, 8'hff);
    cmp(dac_codes.osc_tune, 6'h15);
    cmp(serial_out_en, 1'b0);
    u_host.stray({5'h00, ADDR_OSC_TUNE, 8'hbf});
    cyc(8);
    cmp({bias_shutdown_output, dac_codes.osc_tune}, 7'h15);
    $display("t_ctrl done");
  endtask

  initial begin
    srst = 1'b1;
    tx_mode_input = 1'b0;
    measurement_window_input = 1'b0;
    diversity_window_input = 1'b0;
    adc_data_in = 8'h00;
    rssi_level_in = 8'h00;
    cyc(5);
    srst = 1'b0;
    cyc(4);
    cmp(ground_switch, 3'h7);
    t_sense();
    t_rssi();
    t_ant();
    t_ctrl();
    final_report();
  end
endmodule // tb
